/* File: hdl/bmsc_regs.svh */
// Purpose: constants for the board-management signal block
// Assumes: 250 MHz core clock
// Notes: times in ns, debounce count derived from clock period
`ifndef BMSC_REGS_SVH
`define BMSC_REGS_SVH
`define BMSC_CLK_PERIOD_NS 4
`define BMSC_DEBOUNCE_NS 1000000
`define BMSC_DEBOUNCE_CYC (`BMSC_DEBOUNCE_NS / `BMSC_CLK_PERIOD_NS)
`define BMSC_TACH_GATE_CYC 250000000
`define BMSC_PWM_PERIOD_CYC 10000
`define BMSC_SPI_DIV 4
`define BMSC_VCODE_095 3'h2
`define BMSC_VCODE_1025 3'h1
`define BMSC_REV0 3'h0
`define BMSC_REV1 3'h1
`define BMSC_SLOT_MAX 3'h3
`define BMSC_FAN_NUM 4
`define BMSC_TACH_NUM 8
`define BMSC_RXLOSS_NUM 16
`endif

/* File: hdl/bmsc_pkg.sv */
// Purpose: types for the board-management signal block
// Assumes: nothing
// Notes: volt code meanings and flash sequence states
package bmsc_pkg;
  typedef enum logic [1:0] {
    BMSC_V_UNKNOWN = 2'h0,
    BMSC_V_0P95 = 2'h1,
    BMSC_V_1P025 = 2'h2
  } bmsc_volt_t;
  typedef enum logic [2:0] {
    BMSC_FL_IDLE = 3'h0,
    BMSC_FL_PATH = 3'h1,
    BMSC_FL_UNPROT = 3'h3,
    BMSC_FL_ACTIVE = 3'h2,
    BMSC_FL_DONE = 3'h6
  } bmsc_flash_t;
endpackage

/* File: hdl/bmsc_spi_master.sv */
// Purpose: byte-wide SPI master, mode 0, MSB first
// Assumes: start only when busy is low
// Notes: used for both the clock module and the config flash
`timescale 1ns/1ns
`include "bmsc_regs.svh"
module bmsc_spi_master #(
  parameter int DIV = `BMSC_SPI_DIV
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [7:0] tx_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rx_o
);
  initial begin
    if (DIV < 2 || DIV > 255) $error("bmsc_spi_master: DIV out of range");
  end
  logic [7:0] div_q, div_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic sck_q, sck_d, busy_q, busy_d, done_q, done_d;
  always_comb begin
    div_d = div_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rx_d = rx_q;
    sck_d = sck_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (!busy_q) begin
      if (start_i) begin
        busy_d = 1'b1;
        sh_d = tx_i;
        bit_d = 4'h0;
        div_d = 8'h00;
      end
    end else if (div_q == 8'(DIV - 1)) begin
      div_d = 8'h00;
      sck_d = ~sck_q;
      if (!sck_q) begin
        rx_d = {rx_q[6:0], miso_i};
      end else begin
        sh_d = {sh_q[6:0], 1'b0};
        bit_d = bit_q + 4'h1;
        if (bit_q == 4'h7) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end
      end
    end else begin
      div_d = div_q + 8'h01;
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 8'h00;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      sck_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      sck_q <= sck_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end
  assign sck_o = sck_q;
  assign mosi_o = sh_q[7];
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rx_o = rx_q;
endmodule

/* File: hdl/bmsc_board_mgmt_signal_ctrl.sv */
// Purpose: board-management pin logic: LEDs, fans, straps, status, flash and clock SPI
// Assumes: all inputs are free-running board levels; one core clock
// Notes: ADC samples come in already converted; rail scaling is applied here
`timescale 1ns/1ns
`include "bmsc_regs.svh"
module bmsc_board_mgmt_signal_ctrl
  import bmsc_pkg::*;
#(
  parameter int PWM_PERIOD = `BMSC_PWM_PERIOD_CYC,
  parameter int TACH_GATE = `BMSC_TACH_GATE_CYC,
  parameter int DEBOUNCE = `BMSC_DEBOUNCE_CYC,
  parameter int ADC_W = 10
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic power_led_on_i,
  input wire logic health_ok_i,
  input wire logic [7:0] fan_duty_i [`BMSC_FAN_NUM],
  output logic power_led_drive_o,
  output logic health_led_n_o,
  output logic [`BMSC_FAN_NUM-1:0] fan_pwm_out_o,
  input wire logic [`BMSC_FAN_NUM-1:0] fan_speed_sense_i,
  input wire logic [`BMSC_FAN_NUM-1:0] fan_speed_sense_alt_i,
  output logic [15:0] fan_tach_count_o [`BMSC_TACH_NUM],
  input wire logic [2:0] core_volt_code_i,
  output logic [1:0] core_volt_sel_o,
  input wire logic [ADC_W-1:0] adc_ch_i [5],
  output logic [ADC_W:0] rail_mv_o [5],
  input wire logic input_power_good_i,
  input wire logic inrush_fault_n_i,
  output logic input_power_ok_o,
  output logic inrush_shutdown_o,
  input wire logic backplane_side_i,
  input wire logic [2:0] slot_number_bit_i,
  output logic backplane_right_o,
  output logic [2:0] slot_number_o,
  output logic slot_valid_o,
  input wire logic [2:0] board_revision_bit_i,
  output logic [2:0] board_revision_o,
  input wire logic hub_reset_req_i,
  output logic hub_reset_n_o,
  input wire logic usb_overcurrent_n_i,
  output logic usb_fuse_tripped_o,
  input wire logic [`BMSC_RXLOSS_NUM-1:0] port_rx_loss_i,
  output logic [7:0] rx_loss_top_o,
  output logic [7:0] rx_loss_bottom_o,
  input wire logic front_reset_button_n_i,
  output logic front_reset_pressed_o,
  input wire logic flash_prog_start_i,
  input wire logic flash_prog_end_i,
  input wire logic flash_byte_valid_i,
  input wire logic [7:0] flash_byte_i,
  output logic flash_byte_ready_o,
  output logic flash_path_select_o,
  output logic flash_wp_ctrl_o,
  output logic flash_cs_n_o,
  output logic flash_sck_o,
  output logic flash_si_o,
  input wire logic flash_so_i,
  output logic [7:0] flash_rx_o,
  input wire logic clk_spi_start_i,
  input wire logic clk_spi_end_i,
  input wire logic [7:0] clk_spi_byte_i,
  output logic clk_spi_busy_o,
  output logic [7:0] clk_spi_rx_o,
  output logic clock_chip_select_o,
  output logic clock_spi_sck_o,
  output logic clock_spi_mosi_o,
  input wire logic clock_spi_miso_i
);
  localparam int NSYNC = 4 + 4 + 3 + 2 + 1 + 3 + 3 + 1 + 16 + 1;
  initial begin
    if (PWM_PERIOD < 256 || TACH_GATE < 2 || DEBOUNCE < 1 || ADC_W < 2 || ADC_W > 15)
      $error("bmsc_board_mgmt_signal_ctrl: parameter out of range");
  end
  // Two-stage synchroniser for every status/strap/button input
  logic [NSYNC-1:0] raw, s1_q, s2_q;
  assign raw = {front_reset_button_n_i, port_rx_loss_i, usb_overcurrent_n_i, board_revision_bit_i,
    slot_number_bit_i, backplane_side_i, input_power_good_i, inrush_fault_n_i, core_volt_code_i,
    fan_speed_sense_alt_i, fan_speed_sense_i};
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic [3:0] t_main, t_alt;
  logic [2:0] vcode, slot_s, rev_s;
  logic pg_s, hf_s, side_s, oc_s, btn_s;
  logic [15:0] rxl_s;
  assign {btn_s, rxl_s, oc_s, rev_s, slot_s, side_s, pg_s, hf_s, vcode, t_alt, t_main} = s2_q;
  // Tach order: fan n uses sense n*2 (main) and n*2+1 (alt)
  logic [7:0] tach_s, tach_prev_q;
  assign tach_s = {t_alt[3], t_main[3], t_alt[2], t_main[2], t_alt[1], t_main[1], t_alt[0], t_main[0]};
  function automatic logic [1:0] volt_decode(input logic [2:0] c);
    case (c)
      `BMSC_VCODE_095: volt_decode = BMSC_V_0P95;
      `BMSC_VCODE_1025: volt_decode = BMSC_V_1P025;
      default: volt_decode = BMSC_V_UNKNOWN;
    endcase
  endfunction
  // Status and LED registers
  logic [ADC_W:0] rail_d [5], rail_q [5];
  logic st_pled_q, st_hled_q, st_pg_q, st_hf_q, st_side_q, st_sv_q, st_oc_q, st_hub_q;
  logic [1:0] st_volt_q;
  logic [2:0] st_slot_q, st_rev_q;
  logic [7:0] st_top_q, st_bot_q;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      rail_d[i] = (i < 2) ? {1'b0, adc_ch_i[i]} : {adc_ch_i[i], 1'b0};
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_pled_q <= 1'b0;
      st_hled_q <= 1'b1;
      st_pg_q <= 1'b0;
      st_hf_q <= 1'b0;
      st_side_q <= 1'b0;
      st_sv_q <= 1'b0;
      st_oc_q <= 1'b0;
      st_hub_q <= 1'b0;
      st_volt_q <= 2'h0;
      st_slot_q <= 3'h0;
      st_rev_q <= 3'h0;
      st_top_q <= 8'h00;
      st_bot_q <= 8'h00;
      for (int i = 0; i < 5; i++) rail_q[i] <= '0;
    end else begin
      st_pled_q <= power_led_on_i;
      st_hled_q <= ~health_ok_i;
      st_pg_q <= pg_s;
      st_hf_q <= ~hf_s;
      st_side_q <= side_s;
      st_slot_q <= slot_s;
      st_sv_q <= (slot_s <= `BMSC_SLOT_MAX);
      st_rev_q <= rev_s;
      st_volt_q <= volt_decode(vcode);
      st_hub_q <= ~hub_reset_req_i;
      st_oc_q <= ~oc_s;
      for (int p = 0; p < 8; p++) begin
        st_top_q[p] <= rxl_s[15-2*p];
        st_bot_q[p] <= rxl_s[14-2*p];
      end
      for (int i = 0; i < 5; i++) rail_q[i] <= rail_d[i];
    end
  end
  // Debounce: report press only after a stable low for DEBOUNCE cycles
  logic [31:0] db_cnt_q, db_cnt_d;
  logic btn_q, btn_d;
  always_comb begin
    db_cnt_d = db_cnt_q;
    btn_d = btn_q;
    if ((~btn_s) == btn_q) begin
      db_cnt_d = 32'h0;
    end else if (db_cnt_q == 32'(DEBOUNCE - 1)) begin
      db_cnt_d = 32'h0;
      btn_d = ~btn_s;
    end else begin
      db_cnt_d = db_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      db_cnt_q <= 32'h0;
      btn_q <= 1'b0;
    end else begin
      db_cnt_q <= db_cnt_d;
      btn_q <= btn_d;
    end
  end
  // Fan PWM and tach gate; tach counts saturate rather than wrap, PWM and gate counters wrap
  logic [31:0] pwm_cnt_q, pwm_cnt_d, gate_q, gate_d;
  logic [3:0] pwm_q, pwm_d;
  logic [15:0] tc_q [8], tc_d [8], tl_q [8], tl_d [8];
  always_comb begin
    pwm_cnt_d = (pwm_cnt_q == 32'(PWM_PERIOD - 1)) ? 32'h0 : pwm_cnt_q + 32'h1;
    gate_d = (gate_q == 32'(TACH_GATE - 1)) ? 32'h0 : gate_q + 32'h1;
    for (int f = 0; f < 4; f++) begin
      pwm_d[f] = ((pwm_cnt_q * 256) < (32'(PWM_PERIOD) * {24'h0, fan_duty_i[f]}));
    end
    for (int t = 0; t < 8; t++) begin
      tl_d[t] = tl_q[t];
      tc_d[t] = tc_q[t];
      if (tach_s[t] && !tach_prev_q[t] && tc_q[t] != 16'hffff) tc_d[t] = tc_q[t] + 16'h1;
      if (gate_q == 32'(TACH_GATE - 1)) begin
        tl_d[t] = tc_d[t];
        tc_d[t] = 16'h0;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_cnt_q <= 32'h0;
      gate_q <= 32'h0;
      pwm_q <= 4'h0;
      tach_prev_q <= 8'hff; // Matches synchroniser reset, no false edge
      for (int t = 0; t < 8; t++) begin
        tc_q[t] <= 16'h0;
        tl_q[t] <= 16'h0;
      end
    end else begin
      pwm_cnt_q <= pwm_cnt_d;
      gate_q <= gate_d;
      pwm_q <= pwm_d;
      tach_prev_q <= tach_s;
      for (int t = 0; t < 8; t++) begin
        tc_q[t] <= tc_d[t];
        tl_q[t] <= tl_d[t];
      end
    end
  end
  // Flash programming sequence: path, then unprotect, then chip select
  bmsc_flash_t fl_q, fl_d;
  logic fl_start, fl_busy, fl_done;
  logic fl_path_q, fl_wp_q, fl_csn_q, fl_rdy_q;
  always_comb begin
    fl_d = fl_q;
    fl_start = 1'b0;
    case (fl_q)
      BMSC_FL_IDLE: if (flash_prog_start_i) fl_d = BMSC_FL_PATH;
      BMSC_FL_PATH: fl_d = BMSC_FL_UNPROT;
      BMSC_FL_UNPROT: fl_d = BMSC_FL_ACTIVE;
      BMSC_FL_ACTIVE: begin
        if (flash_prog_end_i && !fl_busy) begin
          fl_d = BMSC_FL_DONE;
        end else begin
          fl_start = flash_byte_valid_i && fl_rdy_q;
        end
      end
      BMSC_FL_DONE: fl_d = BMSC_FL_IDLE;
      default: fl_d = BMSC_FL_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fl_q <= BMSC_FL_IDLE;
      fl_path_q <= 1'b0;
      fl_wp_q <= 1'b0;
      fl_csn_q <= 1'b1;
      fl_rdy_q <= 1'b0;
    end else begin
      fl_q <= fl_d;
      fl_path_q <= (fl_d != BMSC_FL_IDLE);
      fl_wp_q <= (fl_d == BMSC_FL_UNPROT) || (fl_d == BMSC_FL_ACTIVE);
      fl_csn_q <= (fl_d != BMSC_FL_ACTIVE);
      fl_rdy_q <= (fl_d == BMSC_FL_ACTIVE) && !fl_start && !fl_busy && !fl_done; // Late after a byte, never early
    end
  end
  bmsc_spi_master u_flash_spi (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .start_i(fl_start),
    .tx_i(flash_byte_i),
    .miso_i(flash_so_i),
    .sck_o(flash_sck_o),
    .mosi_o(flash_si_o),
    .busy_o(fl_busy),
    .done_o(fl_done),
    .rx_o(flash_rx_o)
  );
  // Clock module SPI: select held low from first byte until end request
  logic ck_start, ck_busy, ck_sel_q, ck_sel_d, ck_busy_q;
  assign ck_start = clk_spi_start_i && !ck_busy && !ck_busy_q;
  always_comb begin
    ck_sel_d = ck_sel_q;
    if (ck_start) ck_sel_d = 1'b0;
    else if (clk_spi_end_i && !ck_busy && !ck_busy_q) ck_sel_d = 1'b1;
  end
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ck_sel_q <= 1'b1;
      ck_busy_q <= 1'b0;
    end else begin
      ck_sel_q <= ck_sel_d;
      ck_busy_q <= ck_busy || ck_start;
    end
  end
  bmsc_spi_master u_clock_spi (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .start_i(ck_start),
    .tx_i(clk_spi_byte_i),
    .miso_i(clock_spi_miso_i),
    .sck_o(clock_spi_sck_o),
    .mosi_o(clock_spi_mosi_o),
    .busy_o(ck_busy),
    .done_o(),
    .rx_o(clk_spi_rx_o)
  );
  assign power_led_drive_o = st_pled_q;
  assign health_led_n_o = st_hled_q;
  assign fan_pwm_out_o = pwm_q;
  assign fan_tach_count_o = tl_q;
  assign core_volt_sel_o = st_volt_q;
  assign rail_mv_o = rail_q;
  assign input_power_ok_o = st_pg_q;
  assign inrush_shutdown_o = st_hf_q;
  assign backplane_right_o = st_side_q;
  assign slot_number_o = st_slot_q;
  assign slot_valid_o = st_sv_q;
  assign board_revision_o = st_rev_q;
  assign hub_reset_n_o = st_hub_q;
  assign usb_fuse_tripped_o = st_oc_q;
  assign rx_loss_top_o = st_top_q;
  assign rx_loss_bottom_o = st_bot_q;
  assign front_reset_pressed_o = btn_q;
  assign flash_byte_ready_o = fl_rdy_q;
  assign flash_path_select_o = fl_path_q;
  assign flash_wp_ctrl_o = fl_wp_q;
  assign flash_cs_n_o = fl_csn_q;
  assign clk_spi_busy_o = ck_busy_q;
  assign clock_chip_select_o = ck_sel_q;
endmodule

/* File: bench/bmsc_props.sv */
// Purpose: port checks for the board signal block
// Assumes: inputs held 5 cycles cover sync latency
// Notes: flash order checked on output edges
`timescale 1ns/1ns
module bmsc_props (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic power_led_on_i,
  input wire logic health_ok_i,
  input wire logic power_led_drive_o,
  input wire logic health_led_n_o,
  input wire logic input_power_good_i,
  input wire logic inrush_fault_n_i,
  input wire logic input_power_ok_o,
  input wire logic inrush_shutdown_o,
  input wire logic hub_reset_req_i,
  input wire logic hub_reset_n_o,
  input wire logic usb_overcurrent_n_i,
  input wire logic usb_fuse_tripped_o,
  input wire logic flash_path_select_o,
  input wire logic flash_wp_ctrl_o,
  input wire logic flash_cs_n_o,
  input wire logic clk_spi_start_i,
  input wire logic clk_spi_busy_o,
  input wire logic clock_chip_select_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_PWR_LED: assert property ($stable(power_led_on_i) [*5] |-> power_led_drive_o == power_led_on_i)
    else $error("power led off its request");
  AST_HEALTH_LED: assert property ($stable(health_ok_i) [*5] |-> health_led_n_o == !health_ok_i)
    else $error("health led level wrong");
  AST_HUB_RESET: assert property ($stable(hub_reset_req_i) [*5] |-> hub_reset_n_o == !hub_reset_req_i)
    else $error("hub reset level wrong");
  AST_FUSE: assert property ($stable(usb_overcurrent_n_i) [*5] |-> usb_fuse_tripped_o == !usb_overcurrent_n_i)
    else $error("fuse flag wrong");
  AST_HOTSWAP: assert property ($stable({input_power_good_i, inrush_fault_n_i}) [*5] |->
    input_power_ok_o == input_power_good_i && inrush_shutdown_o == !inrush_fault_n_i)
    else $error("hot swap status wrong");
  AST_FLASH_SEQ: assert property ($rose(flash_path_select_o) |-> !flash_wp_ctrl_o && flash_cs_n_o
    ##1 flash_wp_ctrl_o && flash_cs_n_o ##1 !flash_cs_n_o)
    else $error("flash open order wrong");
  AST_FLASH_CS: assert property (!flash_cs_n_o |-> flash_wp_ctrl_o && flash_path_select_o)
    else $error("flash select without unprotect");
  AST_CLK_SEL: assert property (clk_spi_start_i && !clk_spi_busy_o |-> ##[1:2] !clock_chip_select_o)
    else $error("clock select not asserted");
endmodule
bind bmsc_board_mgmt_signal_ctrl bmsc_props u_props (.core_clk_i, .rstn_i, .power_led_on_i, .health_ok_i,
  .power_led_drive_o, .health_led_n_o, .input_power_good_i, .inrush_fault_n_i, .input_power_ok_o,
  .inrush_shutdown_o, .hub_reset_req_i, .hub_reset_n_o, .usb_overcurrent_n_i, .usb_fuse_tripped_o,
  .flash_path_select_o, .flash_wp_ctrl_o, .flash_cs_n_o, .clk_spi_start_i, .clk_spi_busy_o,
  .clock_chip_select_o);

/* File: bench/bmsc_spi_model.sv */
// Purpose: SPI slave standing for flash or clock module
// Assumes: mode 0, MSB first, fixed reply byte
// Notes: output wanders while deselected
`timescale 1ns/1ns
module bmsc_spi_model #(
  parameter logic [7:0] REPLY = 8'h00
) (
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic [7:0] got_o
);
  logic [7:0] sh;
  int n;
  initial miso_o = 1'b0;
  // Toggled every 3 ns while deselected, so no stale bit
  always #3 if (cs_n_i) miso_o = ~miso_o;
  always @(negedge cs_n_i) begin
    n = 0;
    sh = REPLY;
    miso_o = sh[7];
  end
  always @(posedge sck_i) if (!cs_n_i) begin
    got_o = {got_o[6:0], mosi_i};
    n++;
  end
  always @(negedge sck_i) if (!cs_n_i) begin
    sh = (n % 8 == 0) ? REPLY : sh << 1;
    miso_o = sh[7];
  end
endmodule

/* File: bench/tb_top.sv */
// Purpose: directed bench for the board signal block
// Assumes: short gate, debounce and pwm period
// Notes: tach lines come from a free counter
`timescale 1ns/1ns
module tb_top;
  logic core_clk_i = 0;
  logic rstn_i = 0;
  logic pwr = 0, hok = 0, hubr = 0, ocn = 1, pg = 0, hfn = 1, bps = 0, btn_n = 1;
  logic [7:0] duty [4] = '{4{8'h00}};
  logic [7:0] tc = 0;
  logic [15:0] tcnt [8];
  logic [2:0] vc = 0, sl = 0, rev = 0, slo, rev_o;
  logic [1:0] vsel;
  logic [9:0] adc [5] = '{5{10'h000}};
  logic [10:0] rail [5];
  logic [15:0] rxl = 0;
  logic [7:0] rtop, rbot, fb = 0, frx, cb = 0, crx, fgot, cgot;
  logic pwr_o, hled_n, pok, ishut, bright, svalid, hub_n, fuse, pressed;
  logic [3:0] pwm;
  logic fstart = 0, fend = 0, fvalid = 0, fready, fpath, fwp, fcs_n, fsck, fsi, fso;
  logic cstart = 0, cend = 0, cbusy, csel_n, csck, cmosi, cmiso;
  int error_cnt = 0, checks_done = 0, k, j, e, hi [4];
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) #1 tc++;
  bmsc_board_mgmt_signal_ctrl #(.PWM_PERIOD(256), .TACH_GATE(100), .DEBOUNCE(4)) dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .power_led_on_i(pwr), .health_ok_i(hok), .fan_duty_i(duty),
    .power_led_drive_o(pwr_o), .health_led_n_o(hled_n), .fan_pwm_out_o(pwm), .fan_speed_sense_i(tc[4:1]),
    .fan_speed_sense_alt_i(tc[3:0]), .fan_tach_count_o(tcnt), .core_volt_code_i(vc), .core_volt_sel_o(vsel),
    .adc_ch_i(adc), .rail_mv_o(rail), .input_power_good_i(pg), .inrush_fault_n_i(hfn), .input_power_ok_o(pok),
    .inrush_shutdown_o(ishut), .backplane_side_i(bps), .slot_number_bit_i(sl), .backplane_right_o(bright),
    .slot_number_o(slo), .slot_valid_o(svalid), .board_revision_bit_i(rev), .board_revision_o(rev_o),
    .hub_reset_req_i(hubr), .hub_reset_n_o(hub_n), .usb_overcurrent_n_i(ocn), .usb_fuse_tripped_o(fuse),
    .port_rx_loss_i(rxl), .rx_loss_top_o(rtop), .rx_loss_bottom_o(rbot), .front_reset_button_n_i(btn_n),
    .front_reset_pressed_o(pressed), .flash_prog_start_i(fstart), .flash_prog_end_i(fend),
    .flash_byte_valid_i(fvalid), .flash_byte_i(fb), .flash_byte_ready_o(fready), .flash_path_select_o(fpath),
    .flash_wp_ctrl_o(fwp), .flash_cs_n_o(fcs_n), .flash_sck_o(fsck), .flash_si_o(fsi), .flash_so_i(fso),
    .flash_rx_o(frx), .clk_spi_start_i(cstart), .clk_spi_end_i(cend), .clk_spi_byte_i(cb),
    .clk_spi_busy_o(cbusy), .clk_spi_rx_o(crx), .clock_chip_select_o(csel_n), .clock_spi_sck_o(csck),
    .clock_spi_mosi_o(cmosi), .clock_spi_miso_i(cmiso));
  // Flash chip select passes through the path switch; clock and data reach the model directly
  bmsc_spi_model #(.REPLY(8'hc3)) u_flash (.cs_n_i(fcs_n | !fpath), .sck_i(fsck), .mosi_i(fsi),
    .miso_o(fso), .got_o(fgot));
  bmsc_spi_model #(.REPLY(8'h5a)) u_clkmod (.cs_n_i(csel_n), .sck_i(csck), .mosi_i(cmosi),
    .miso_o(cmiso), .got_o(cgot));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #40000;
    error_cnt++;
    finish_test;
  end
  initial begin
    tick(6);
    rstn_i = 1;
    for (k = 0; k < 16; k++) begin
      {pwr, hok, hubr, ocn, pg, hfn, bps} = {7{k[0]}};
      {vc, sl, rev} = {3{k[2:0]}};
      rxl = 16'h0001 << k;
      for (j = 0; j < 5; j++) adc[j] = 10'(k * 61 + j * 200);
      tick(6);
      check("pwr_led", pwr_o, k[0]);
      check("hlth_led", hled_n, !k[0]);
      check("hub_rst", hub_n, !k[0]);
      check("fuse", fuse, !k[0]);
      check("pgood", pok, k[0]);
      check("shutdn", ishut, !k[0]);
      check("bp_right", bright, k[0]);
      check("slot", {svalid, slo}, {k[2:0] <= 3, k[2:0]});
      check("rev", rev_o, k[2:0]);
      check("volt", vsel, k[2:0] == 2 ? 1 : k[2:0] == 1 ? 2 : 0);
      check("rx_top", rtop, k[0] ? 8'h01 << ((15 - k) / 2) : 0);
      check("rx_bot", rbot, k[0] ? 0 : 8'h01 << ((14 - k) / 2));
      for (j = 0; j < 5; j++) check("rail", rail[j], j < 2 ? adc[j] : 2 * adc[j]);
    end
    btn_n = 0;
    tick(1);
    btn_n = 1;
    tick(12);
    check("btn_glitch", pressed, 0);
    btn_n = 0;
    tick(16);
    check("btn_press", pressed, 1);
    btn_n = 1;
    tick(16);
    check("btn_free", pressed, 0);
    duty = '{8'h00, 8'h40, 8'h80, 8'hff};
    tick(300);
    hi = '{4{0}};
    repeat (256) begin
      tick(1);
      for (j = 0; j < 4; j++) hi[j] += pwm[j];
    end
    for (j = 0; j < 4; j++) check("pwm_duty", hi[j], duty[j]);
    for (j = 0; j < 8; j++) begin
      e = 100 / (1 << (j / 2 + 2 - j % 2));
      check("tach", tcnt[j] + 1 >= e && tcnt[j] <= e + 1, 1);
    end
    fstart = 1;
    tick(1);
    fstart = 0;
    for (k = 0; k < 50 && fready !== 1; k++) tick(1);
    check("fl_open", {fpath, fwp, fcs_n}, 3'b110);
    for (j = 0; j < 2; j++) begin
      fb = j ? 8'h3c : 8'ha5;
      fvalid = 1;
      tick(1);
      fvalid = 0;
      tick(2);
      for (k = 0; k < 300 && fready !== 1; k++) tick(1);
      check("fl_tx", fgot, fb);
      check("fl_rx", frx, 8'hc3);
    end
    fend = 1;
    for (k = 0; k < 300 && fpath !== 0; k++) tick(1);
    fend = 0;
    check("fl_close", {fpath, fcs_n}, 2'b01);
    for (j = 0; j < 2; j++) begin
      cb = j ? 8'h69 : 8'h96;
      cstart = 1;
      tick(1);
      cstart = 0;
      tick(2);
      for (k = 0; k < 300 && cbusy !== 0; k++) tick(1);
      check("clk_tx", cgot, cb);
      check("clk_rx", crx, 8'h5a);
      check("clk_sel", csel_n, 0);
    end
    cend = 1;
    tick(1);
    cend = 0;
    tick(3);
    check("clk_desel", csel_n, 1);
    finish_test;
  end
endmodule
